// ### src/acd_pkg.sv
// Shared constants and types for the amplifier channel diagnostic control
package acd_pkg;
  localparam int NCH = 4;
  // Control command codes
  typedef enum logic [2:0] {
    ACD_CMD_NOP, ACD_CMD_PLAY, ACD_CMD_MUTE, ACD_CMD_HIZ, ACD_CMD_CLEAR,
    ACD_CMD_DIAG, ACD_CMD_TWEETER, ACD_CMD_CFG
  } acd_cmd_t;
  // Gain codes: 12, 20, 26, 32 dB
  localparam logic [1:0] GAIN_12DB = 2'h0;
  localparam logic [1:0] GAIN_20DB = 2'h1;
  localparam logic [1:0] GAIN_26DB = 2'h2;
  localparam logic [1:0] GAIN_32DB = 2'h3;
  // Ramp step levels, full gain level
  localparam logic [4:0] RAMP_FULL = 5'h1f;
  // Clip/warning pin routing
  localparam logic [1:0] PIN_CLIP = 2'h0;
  localparam logic [1:0] PIN_WARN = 2'h1;
  localparam logic [1:0] PIN_BOTH = 2'h2;
  localparam logic [1:0] PIN_TWEETER = 2'h3;
  // Diagnostic result codes
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_GND = 3'h1;
  localparam logic [2:0] RES_SUP = 3'h2;
  localparam logic [2:0] RES_SHORT = 3'h3;
  localparam logic [2:0] RES_OPEN = 3'h4;
  localparam logic [2:0] RES_SKIP = 3'h7;
  // Register address that must not be written during diagnostics
  localparam logic [7:0] REG_DIAG_CTRL = 8'h0c;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int RAMP_STEP_US = 10;
  localparam int RAMP_STEP_CYC = RAMP_STEP_US * CLK_MHZ;
  localparam int PHASE_US = 20;
  localparam int PHASE_CYC = PHASE_US * CLK_MHZ;
  localparam int PULSE_KHZ = 250;
  localparam int PULSE_CYC = (CLK_MHZ * 1000) / PULSE_KHZ;
  localparam int NPHASE = 4;
  // Channel modes
  typedef enum logic [1:0] {ACD_HIZ, ACD_MUTED, ACD_PLAY} acd_mode_t;
endpackage : acd_pkg

// ### src/acd_if.sv
// Command and status carrier between host and amplifier control
`timescale 1ns/100ps
interface acd_if;
  import acd_pkg::*;
  logic cmd_valid;
  acd_cmd_t cmd;
  logic [3:0] cmd_chan;
  logic [1:0] cmd_gain;
  logic [1:0] cmd_pin_sel;
  logic cmd_dc_red;
  logic [7:0] cmd_reg;
  logic cmd_ready;
  logic [3:0] hiz;
  logic [3:0] playing;
  logic diag_busy;
  logic diag_done;
  logic [11:0] diag_result;
  logic clip_warn_pin;
  modport dev (input cmd_valid, cmd, cmd_chan, cmd_gain, cmd_pin_sel, cmd_dc_red, cmd_reg,
    output cmd_ready, hiz, playing, diag_busy, diag_done, diag_result, clip_warn_pin);
  modport host (output cmd_valid, cmd, cmd_chan, cmd_gain, cmd_pin_sel, cmd_dc_red, cmd_reg,
    input cmd_ready, hiz, playing, diag_busy, diag_done, diag_result, clip_warn_pin);
endinterface : acd_if

// ### src/acd_ramp.sv
// One channel gain ramp: steps level toward target
`timescale 1ns/100ps
module acd_ramp (
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic up,
  input wire logic hard_off,
  output logic [4:0] level,
  output logic at_zero
);
  import acd_pkg::*;
  logic [4:0] level_q, level_d;
  // Next level: gradual steps, immediate zero on fault
  always_comb begin
    level_d = level_q;
    if (hard_off) begin
      level_d = 5'h00;
    end else if (step && up && level_q != RAMP_FULL) begin
      level_d = level_q + 5'h01;
    end else if (step && !up && level_q != 5'h00) begin
      level_d = level_q - 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 5'h00;
    end else begin
      level_q <= level_d;
    end
  end
  assign level = level_q;
  assign at_zero = (level_q == 5'h00);
endmodule : acd_ramp

// ### src/acd_dev.sv
// Device end: channel modes, gain ramp, faults, load and tweeter diagnostics
`timescale 1ns/100ps
module acd_dev (
  input wire logic clk,
  input wire logic rst,
  acd_if.dev bus,
  input wire logic [3:0] overvoltage_fault,
  input wire logic [3:0] undervoltage_fault,
  input wire logic [3:0] overcurrent_fault,
  input wire logic [3:0] overtemp_fault,
  input wire logic [3:0] dc_fault,
  input wire logic [3:0] clip_in,
  input wire logic overtemp_warning,
  input wire logic [3:0] cycle_current_limiter,
  input wire logic [3:0] tweeter_level,
  input wire logic [3:0] sense_gnd,
  input wire logic [3:0] sense_sup,
  input wire logic [3:0] sense_short,
  input wire logic [3:0] sense_open,
  output logic [7:0] gain_sel,
  output logic dc_reduce_en,
  output logic [19:0] gain_level,
  output logic [3:0] switch_en
);
  import acd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  logic [23:0] s1_q, s2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 24'h000000;
      s2_q <= 24'h000000;
    end else begin
      s1_q <= {overvoltage_fault, undervoltage_fault, overcurrent_fault, overtemp_fault, dc_fault, clip_in};
      s2_q <= s1_q;
    end
  end
  logic [23:0] s3_q, s4_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      s3_q <= 24'h000000;
      s4_q <= 24'h000000;
    end else begin
      s3_q <= {3'h0, overtemp_warning, cycle_current_limiter, sense_gnd, sense_sup, sense_short, sense_open};
      s4_q <= s3_q;
    end
  end
  logic [3:0] fault_now, clip_s, cbc_s, gnd_s, sup_s, sht_s, opn_s;
  logic warn_s;
  assign fault_now = s2_q[23:20] | s2_q[19:16] | s2_q[15:12] | s2_q[11:8] | s2_q[7:4];
  assign clip_s = s2_q[3:0];
  assign warn_s = s4_q[20];
  assign cbc_s = s4_q[19:16];
  assign gnd_s = s4_q[15:12];
  assign sup_s = s4_q[11:8];
  assign sht_s = s4_q[7:4];
  assign opn_s = s4_q[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Ramp step enable divider
  logic [15:0] rdiv_q, rdiv_d;
  logic ramp_step;
  assign ramp_step = (rdiv_q == 16'(RAMP_STEP_CYC - 1));
  always_comb begin
    rdiv_d = ramp_step ? 16'h0000 : rdiv_q + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rdiv_q <= 16'h0000;
    end else begin
      rdiv_q <= rdiv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and channel modes
  typedef enum logic [1:0] {DG_IDLE, DG_RUN, DG_DONE} acd_dstate_t;
  acd_dstate_t dst_q, dst_d;
  acd_mode_t mode_q [NCH];
  acd_mode_t mode_d [NCH];
  logic [7:0] gain_q, gain_d;
  logic dcr_q, dcr_d;
  logic [1:0] psel_q, psel_d;
  logic [3:0] latch_q, latch_d;
  logic [3:0] twt_q, twt_d;
  logic [3:0] zero;
  logic [3:0] up;
  logic cmd_go;
  assign cmd_go = bus.cmd_valid && bus.cmd_ready;
  always_comb begin
    gain_d = gain_q;
    dcr_d = dcr_q;
    psel_d = psel_q;
    latch_d = latch_q | fault_now;
    twt_d = twt_q;
    for (int c = 0; c < NCH; c++) begin
      mode_d[c] = mode_q[c];
      if (cmd_go && bus.cmd_chan[c]) begin
        unique case (bus.cmd)
          ACD_CMD_PLAY: if (!latch_q[c]) mode_d[c] = ACD_PLAY;
          ACD_CMD_MUTE: if (mode_q[c] == ACD_PLAY) mode_d[c] = ACD_MUTED;
          ACD_CMD_HIZ: if (zero[c]) mode_d[c] = ACD_HIZ;
          ACD_CMD_CLEAR: begin
            latch_d[c] = fault_now[c];
            if (!fault_now[c]) mode_d[c] = ACD_PLAY;
          end
          ACD_CMD_CFG: gain_d[2*c +: 2] = bus.cmd_gain;
          default: ;
        endcase
      end
      if (latch_d[c]) mode_d[c] = ACD_HIZ;
    end
    if (cmd_go && bus.cmd == ACD_CMD_CFG) begin
      dcr_d = bus.cmd_dc_red;
      psel_d = bus.cmd_pin_sel;
    end
    if (cmd_go && bus.cmd == ACD_CMD_TWEETER) begin
      twt_d = bus.cmd_chan;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_q <= {4{GAIN_12DB}};
      dcr_q <= 1'b0;
      psel_q <= PIN_WARN;
      latch_q <= 4'h0;
      twt_q <= 4'h0;
      for (int c = 0; c < NCH; c++) begin
        mode_q[c] <= ACD_HIZ;
      end
    end else begin
      gain_q <= gain_d;
      dcr_q <= dcr_d;
      psel_q <= psel_d;
      latch_q <= latch_d;
      twt_q <= twt_d;
      for (int c = 0; c < NCH; c++) begin
        mode_q[c] <= mode_d[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel gain ramps
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ramp
      assign up[g] = (mode_q[g] == ACD_PLAY);
      acd_ramp u_ramp (
        .clk(clk),
        .rst(rst),
        .step(ramp_step),
        .up(up[g]),
        .hard_off(latch_q[g]),
        .level(gain_level[5*g +: 5]),
        .at_zero(zero[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Load diagnostic sequencer
  logic [3:0] hiz_v;
  logic [3:0] dmask_q, dmask_d;
  logic full_q, full_d;
  logic [1:0] ph_q, ph_d;
  logic [11:0] pcnt_q, pcnt_d;
  logic [11:0] res_q, res_d;
  logic [3:0] fg_q, fg_d, fs_q, fs_d, fh_q, fh_d, fo_q, fo_d;
  logic done_q, done_d;
  logic [3:0] dmask_cmd;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      hiz_v[c] = (mode_q[c] == ACD_HIZ);
    end
  end
  assign dmask_cmd = bus.cmd_chan & hiz_v;
  always_comb begin
    dst_d = dst_q;
    dmask_d = dmask_q;
    full_d = full_q;
    ph_d = ph_q;
    pcnt_d = pcnt_q;
    res_d = res_q;
    fg_d = fg_q;
    fs_d = fs_q;
    fh_d = fh_q;
    fo_d = fo_q;
    done_d = 1'b0;
    unique case (dst_q)
      DG_IDLE: begin
        if (cmd_go && bus.cmd == ACD_CMD_DIAG && dmask_cmd != 4'h0) begin
          dst_d = DG_RUN;
          dmask_d = dmask_cmd;
          full_d = (hiz_v == 4'hf);
          ph_d = 2'h0;
          pcnt_d = 12'h000;
          fg_d = 4'h0;
          fs_d = 4'h0;
          fh_d = 4'h0;
          fo_d = 4'h0;
        end
      end
      DG_RUN: begin
        if (pcnt_q == 12'(PHASE_CYC - 1)) begin
          pcnt_d = 12'h000;
          // Sample this phase's sense on every selected channel at once
          unique case (ph_q)
            2'h0: fg_d = gnd_s & dmask_q;
            2'h1: fs_d = sup_s & dmask_q;
            2'h2: fh_d = sht_s & dmask_q;
            2'h3: fo_d = opn_s & dmask_q;
          endcase
          if ((!full_q && ph_q == 2'h1) || ph_q == 2'(NPHASE - 1)) begin
            dst_d = DG_DONE;
          end else begin
            ph_d = ph_q + 2'h1;
          end
        end else begin
          pcnt_d = pcnt_q + 12'h001;
        end
      end
      DG_DONE: begin
        for (int c = 0; c < NCH; c++) begin
          if (!dmask_q[c]) res_d[3*c +: 3] = RES_SKIP;
          else if (fg_q[c]) res_d[3*c +: 3] = RES_GND;
          else if (fs_q[c]) res_d[3*c +: 3] = RES_SUP;
          else if (fh_q[c]) res_d[3*c +: 3] = RES_SHORT;
          else if (fo_q[c]) res_d[3*c +: 3] = RES_OPEN;
          else res_d[3*c +: 3] = RES_OK;
        end
        done_d = 1'b1;
        dst_d = DG_IDLE;
      end
      default: dst_d = DG_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dst_q <= DG_IDLE;
      dmask_q <= 4'h0;
      full_q <= 1'b0;
      ph_q <= 2'h0;
      pcnt_q <= 12'h000;
      res_q <= {4{RES_OK}};
      fg_q <= 4'h0;
      fs_q <= 4'h0;
      fh_q <= 4'h0;
      fo_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      dst_q <= dst_d;
      dmask_q <= dmask_d;
      full_q <= full_d;
      ph_q <= ph_d;
      pcnt_q <= pcnt_d;
      res_q <= res_d;
      fg_q <= fg_d;
      fs_q <= fs_d;
      fh_q <= fh_d;
      fo_q <= fo_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tweeter pulse generator and clip/warning pin routing
  logic [8:0] tdiv_q, tdiv_d;
  logic tpulse_q, tpulse_d;
  logic pin_q, pin_d;
  logic twt_hit;
  assign twt_hit = |(cbc_s & twt_q);
  always_comb begin
    tdiv_d = (tdiv_q == 9'(PULSE_CYC - 1)) ? 9'h000 : tdiv_q + 9'h001;
    tpulse_d = tpulse_q;
    if (tdiv_q == 9'h000) begin
      tpulse_d = twt_hit && (tweeter_level != 4'h0);
    end else if (tdiv_q[8:5] == tweeter_level) begin
      tpulse_d = 1'b0;
    end
    unique case (psel_q)
      PIN_CLIP: pin_d = |clip_s;
      PIN_WARN: pin_d = warn_s;
      PIN_BOTH: pin_d = (|clip_s) | warn_s;
      PIN_TWEETER: pin_d = tpulse_q;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      tdiv_q <= 9'h000;
      tpulse_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      tdiv_q <= tdiv_d;
      tpulse_q <= tpulse_d;
      pin_q <= pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      switch_en[c] = (mode_q[c] != ACD_HIZ);
      bus.playing[c] = (mode_q[c] == ACD_PLAY);
    end
  end
  assign bus.cmd_ready = (dst_q == DG_IDLE);
  assign bus.hiz = hiz_v;
  assign bus.diag_busy = (dst_q != DG_IDLE);
  assign bus.diag_done = done_q;
  assign bus.diag_result = res_q;
  assign bus.clip_warn_pin = pin_q;
  assign gain_sel = gain_q;
  assign dc_reduce_en = dcr_q;
endmodule : acd_dev

// ### src/acd_host.sv
// Host end: turns user requests into commands, keeps the safe diagnostic order
`timescale 1ns/100ps
module acd_host (
  input wire logic clk,
  input wire logic rst,
  acd_if.host bus,
  input wire logic req_valid,
  input wire acd_pkg::acd_cmd_t req_cmd,
  input wire logic [3:0] req_chan,
  input wire logic [1:0] req_gain,
  input wire logic [1:0] req_pin_sel,
  input wire logic req_dc_red,
  input wire logic [7:0] req_reg,
  output logic req_ready,
  output logic [11:0] diag_result,
  output logic diag_done
);
  import acd_pkg::*;
  typedef enum logic [1:0] {HS_IDLE, HS_MUTE, HS_HIZ, HS_DIAG} acd_hstate_t;
  acd_hstate_t st_q, st_d;
  logic [3:0] ch_q, ch_d;
  logic [11:0] res_q, res_d;
  logic dn_q, dn_d;
  logic blocked, single;
  // Tweeter requests need one channel; no 0x0C write during diagnostics
  assign single = (req_chan != 4'h0) && ((req_chan & (req_chan - 4'h1)) == 4'h0);
  assign blocked = (bus.diag_busy && req_reg == REG_DIAG_CTRL)
    || (req_cmd == ACD_CMD_TWEETER && !single);
  // Sequencer: mute then high-impedance before diagnostic
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    res_d = bus.diag_done ? bus.diag_result : res_q;
    dn_d = bus.diag_done;
    bus.cmd_valid = 1'b0;
    bus.cmd = req_cmd;
    bus.cmd_chan = req_chan;
    req_ready = 1'b0;
    unique case (st_q)
      HS_IDLE: begin
        if (req_valid && req_cmd == ACD_CMD_DIAG && (req_chan & bus.playing) != 4'h0) begin
          ch_d = req_chan;
          st_d = HS_MUTE;
          req_ready = 1'b1;
        end else begin
          bus.cmd_valid = req_valid && !blocked;
          req_ready = (bus.cmd_ready && !blocked) || (req_valid && blocked);
        end
      end
      HS_MUTE: begin
        bus.cmd_valid = 1'b1;
        bus.cmd = ACD_CMD_MUTE;
        bus.cmd_chan = ch_q;
        if (bus.cmd_ready) st_d = HS_HIZ;
      end
      HS_HIZ: begin
        bus.cmd_valid = 1'b1;
        bus.cmd = ACD_CMD_HIZ;
        bus.cmd_chan = ch_q;
        if (bus.cmd_ready && (ch_q & ~bus.hiz) == 4'h0) st_d = HS_DIAG;
      end
      HS_DIAG: begin
        bus.cmd_valid = 1'b1;
        bus.cmd = ACD_CMD_DIAG;
        bus.cmd_chan = ch_q;
        if (bus.cmd_ready) st_d = HS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= HS_IDLE;
      ch_q <= 4'h0;
      res_q <= 12'h000;
      dn_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      res_q <= res_d;
      dn_q <= dn_d;
    end
  end
  assign bus.cmd_gain = req_gain;
  assign bus.cmd_pin_sel = req_pin_sel;
  assign bus.cmd_dc_red = req_dc_red;
  assign bus.cmd_reg = req_reg;
  assign diag_result = res_q;
  assign diag_done = dn_q;
endmodule : acd_host

// ### verification/acd_monitor.sv
// Concurrent checks on the host to device command carrier
`timescale 1ns/100ps
module acd_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire acd_pkg::acd_cmd_t cmd,
  input wire logic [3:0] cmd_chan,
  input wire logic [7:0] cmd_reg,
  input wire logic cmd_ready,
  input wire logic [3:0] hiz,
  input wire logic [3:0] playing,
  input wire logic diag_busy,
  input wire logic diag_done,
  input wire logic [11:0] diag_result
);
  import acd_pkg::*;
  logic [14:0] cnt_q, cnt_d;
  logic [3:0] hz_q, hz_d;
  logic busy_q, full_q, full_d, skip_ok, deep_seen;
  ///////////////////////////////
  // Busy length and high-impedance snapshot taken when a test starts
  always_comb begin
    cnt_d = diag_busy ? (busy_q ? cnt_q + 15'h1 : 15'h1) : cnt_q;
    full_d = (diag_busy && !busy_q) ? (hiz == 4'hf) : full_q;
    hz_d = (diag_busy && !busy_q) ? hiz : hz_q;
    skip_ok = 1'b1;
    deep_seen = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (!hz_q[c] && diag_result[3*c+:3] != RES_SKIP) skip_ok = 1'b0;
      if (diag_result[3*c+:3] == RES_SHORT || diag_result[3*c+:3] == RES_OPEN) deep_seen = 1'b1;
    end
  end
  // Registers of the helper state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 15'h0;
      hz_q <= 4'h0;
      busy_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hz_q <= hz_d;
      busy_q <= diag_busy;
      full_q <= full_d;
    end
  end
  ///////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted test requests with and without a high-impedance target
  sequence s_diag_hit;
    cmd_valid && cmd_ready && cmd == ACD_CMD_DIAG && (cmd_chan & hiz) != 4'h0;
  endsequence
  sequence s_diag_miss;
    cmd_valid && cmd_ready && cmd == ACD_CMD_DIAG && (cmd_chan & hiz) == 4'h0;
  endsequence
  // Accepted mute that reaches at least one playing channel
  sequence s_mute_play;
    cmd_valid && cmd_ready && cmd == ACD_CMD_MUTE && (cmd_chan & playing) != 4'h0;
  endsequence
  AST_READY_IDLE: assert property (cmd_ready |-> !diag_busy)
    else $error("ready raised while a test runs");
  AST_DIAG_START: assert property (s_diag_hit |=> diag_busy)
    else $error("accepted test did not start");
  AST_DIAG_REFUSE: assert property (s_diag_miss |=> !diag_busy)
    else $error("test started with no target in high impedance");
  AST_NO_CTRL_WRITE: assert property (diag_busy && cmd_valid |-> cmd_reg != REG_DIAG_CTRL)
    else $error("control register touched during a test");
  AST_FULL_LEN: assert property (diag_done && full_q |-> cnt_q >= 15'h2706 && cnt_q <= 15'h271a)
    else $error("full test length wrong");
  AST_REDUCED_LEN: assert property (diag_done && !full_q |-> cnt_q >= 15'h137e && cnt_q <= 15'h1392)
    else $error("reduced test length wrong");
  AST_REDUCED_SCOPE: assert property (diag_done && !full_q |-> !deep_seen)
    else $error("reduced test reported load short or open");
  AST_SKIP_NONHIZ: assert property (diag_done |-> skip_ok)
    else $error("switching channel was tested");
  AST_STAY_HIZ: assert property (diag_done |-> (hiz & hz_q) == hz_q)
    else $error("channel left high impedance after test");
  AST_DONE_PULSE: assert property (diag_done |=> !diag_done)
    else $error("done pulse too long");
  AST_FROZEN_MODES: assert property (diag_busy && $past(diag_busy) |-> $stable(playing))
    else $error("channel mode changed during a test");
  AST_MUTE_GRADUAL: assert property (s_mute_play |=> (hiz & $past(cmd_chan) & $past(playing)) == 4'h0)
    else $error("mute jumped straight to high impedance");
endmodule : acd_monitor

// ### verification/amp_channel_diagnostic_control_bench.sv
// Self-checking bench: host and device ends joined over the carrier
`timescale 1ns/100ps
module amp_channel_diagnostic_control_bench;
  import acd_pkg::*;
  logic clk, rst, req_valid, req_dc, req_ready, owarn, dc_en, hdone;
  acd_cmd_t req_cmd;
  logic [1:0] req_gain, req_pin;
  logic [7:0] req_reg, gain_sel, exp_gs;
  logic [11:0] hres;
  logic [19:0] glev;
  logic [4:0][3:0] flt;
  logic [3:0] req_chan, clip, ccl, twl, sg, ss, sh, so, sw_en;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  acd_if acd_if_inst ();
  acd_host acd_host_inst (.clk(clk), .rst(rst), .bus(acd_if_inst.host), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_chan(req_chan), .req_gain(req_gain), .req_pin_sel(req_pin),
    .req_dc_red(req_dc), .req_reg(req_reg), .req_ready(req_ready), .diag_result(hres), .diag_done(hdone));
  acd_dev acd_dev_inst (.clk(clk), .rst(rst), .bus(acd_if_inst.dev), .overvoltage_fault(flt[0]),
    .undervoltage_fault(flt[1]), .overcurrent_fault(flt[2]), .overtemp_fault(flt[3]), .dc_fault(flt[4]),
    .clip_in(clip), .overtemp_warning(owarn), .cycle_current_limiter(ccl), .tweeter_level(twl),
    .sense_gnd(sg), .sense_sup(ss), .sense_short(sh), .sense_open(so), .gain_sel(gain_sel),
    .dc_reduce_en(dc_en), .gain_level(glev), .switch_en(sw_en));
  acd_monitor acd_monitor_inst (.clk(clk), .rst(rst), .cmd_valid(acd_if_inst.cmd_valid),
    .cmd(acd_if_inst.cmd), .cmd_chan(acd_if_inst.cmd_chan), .cmd_reg(acd_if_inst.cmd_reg),
    .cmd_ready(acd_if_inst.cmd_ready), .hiz(acd_if_inst.hiz), .playing(acd_if_inst.playing),
    .diag_busy(acd_if_inst.diag_busy), .diag_done(acd_if_inst.diag_done),
    .diag_result(acd_if_inst.diag_result));
  ///////////////////////////////
  // Closing report
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Exact value compare
  task automatic chk_eq(string what, logic [19:0] exp, logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_eq
  // Range compare
  task automatic chk_in(string what, int lo, int hi, logic [19:0] got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : chk_in
  // One request held until the host takes it
  task automatic send(acd_cmd_t c, logic [3:0] ch, logic [1:0] g);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_chan <= ch;
    req_gain <= g;
    req_reg <= 8'($urandom_range(0, 255));
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : send
  // Bounded wait for the end of a load test
  task automatic wait_done();
    int n;
    n = 0;
    while (hdone !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    chk_eq("diag done seen", 1'b1, hdone);
  endtask : wait_done
  // Expected per-channel result from the sense pattern
  function automatic logic [11:0] exp_res(logic full, logic [3:0] tst);
    logic [11:0] r;
    for (int c = 0; c < NCH; c++) begin
      r[3*c+:3] = !tst[c] ? RES_SKIP : sg[c] ? RES_GND : ss[c] ? RES_SUP :
        (full && sh[c]) ? RES_SHORT : (full && so[c]) ? RES_OPEN : RES_OK;
    end
    return r;
  endfunction : exp_res
  ///////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    logic [3:0] m;
    logic [1:0] g;
    int hi;
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = ACD_CMD_NOP;
    req_chan = 4'h0;
    req_gain = 2'h0;
    req_pin = PIN_WARN;
    req_dc = 1'b0;
    req_reg = 8'h00;
    flt = '0;
    {clip, ccl, twl, sg, ss, sh, so, owarn} = '0;
    void'($urandom(32'h9e24a54b));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    {sg, ss, sh, so} <= 16'h8421;
    @(posedge clk);
    send(ACD_CMD_DIAG, 4'hf, GAIN_12DB);
    wait_done();
    chk_eq("full diag", exp_res(1'b1, 4'hf), hres);
    chk_eq("hiz after diag", 4'hf, acd_if_inst.hiz);
    exp_gs = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 4'hf : (i == 1) ? 4'h1 : 4'($urandom_range(1, 15));
      g = (i < 4) ? 2'(3 - i) : 2'($urandom_range(0, 3));
      req_dc <= i[0];
      send(ACD_CMD_CFG, m, g);
      for (int c = 0; c < NCH; c++) begin
        if (m[c]) exp_gs[2*c+:2] = g;
      end
      chk_eq("gain select", exp_gs, gain_sel);
      chk_eq("dc reduction", i[0], dc_en);
    end
    for (int s = 0; s < 3; s++) begin
      req_pin <= 2'(s);
      send(ACD_CMD_CFG, 4'h0, GAIN_12DB);
      for (int k = 0; k < 2; k++) begin
        clip <= k ? 4'h0 : 4'h4;
        owarn <= k[0];
        repeat (6) @(posedge clk);
        chk_eq("pin route", 1'((s == 2) || (s == k)), acd_if_inst.clip_warn_pin);
      end
    end
    {clip, owarn} <= '0;
    for (int k = 0; k < 6; k++) begin
      send(ACD_CMD_CLEAR, 4'h1, GAIN_12DB);
      repeat (1300) @(posedge clk);
      chk_eq("playing after clear", 1'b1, acd_if_inst.playing[0]);
      chk_in("ramp level", 1, 2, glev[4:0]);
      if (k == 5) break;
      flt[k] <= 4'h1;
      repeat (6) @(posedge clk);
      chk_eq("level on fault", 5'h00, glev[4:0]);
      chk_eq("switching on fault", 1'b0, sw_en[0]);
      flt[k] <= 4'h0;
      repeat (4) @(posedge clk);
    end
    send(ACD_CMD_PLAY, 4'h2, GAIN_12DB);
    chk_eq("play command", 1'b1, acd_if_inst.playing[1]);
    send(ACD_CMD_MUTE, 4'h1, GAIN_12DB);
    chk_eq("no hiz right after mute", 1'b0, acd_if_inst.hiz[0]);
    send(ACD_CMD_DIAG, 4'h1, GAIN_12DB);
    chk_eq("diag on switching channel", 1'b0, acd_if_inst.diag_busy);
    {sg, ss, sh, so} <= 16'h8042;
    // Channel 1 plays, so the host mutes and parks it before the test
    send(ACD_CMD_DIAG, 4'he, GAIN_12DB);
    // Control register request while the test runs: the host must swallow it
    req_valid <= 1'b1;
    req_cmd <= ACD_CMD_CFG;
    req_chan <= 4'hf;
    req_gain <= GAIN_32DB;
    req_reg <= REG_DIAG_CTRL;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    wait_done();
    chk_eq("reduced diag", exp_res(1'b0, 4'he), hres);
    chk_eq("gain kept over blocked write", exp_gs, gain_sel);
    req_pin <= PIN_TWEETER;
    twl <= 4'h4;
    send(ACD_CMD_CFG, 4'h0, GAIN_12DB);
    for (int t = 0; t < 2; t++) begin
      ccl <= t ? 4'h2 : 4'h0;
      send(ACD_CMD_TWEETER, 4'h2, GAIN_12DB);
      // Let one whole pulse period pass with the limiter input steady
      repeat (500) @(posedge clk);
      hi = 0;
      repeat (1000) begin
        @(posedge clk);
        hi += int'(acd_if_inst.clip_warn_pin === 1'b1);
      end
      chk_in("tweeter pulses", t ? 248 : 0, t ? 264 : 0, 20'(hi));
    end
    tally_and_finish();
  end
endmodule : amp_channel_diagnostic_control_bench
